// file: dual_rail_fault_supervisor.sv
`timescale 1ns/100ps
`default_nettype none
module dual_rail_fault_supervisor #(
    parameter int unsigned OC_WAIT_TICKS = fault_supervisor_pkg::OC_WAIT_TICKS_DEF
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Bias, enable and soft-start
    input wire logic por_ok,
    input wire logic enable_in,
    input wire logic soft_start_done,
    output logic soft_start_run,
    // Voltage comparators, bit 0 core, bit 1 northbridge
    input wire logic [fault_supervisor_pkg::NUM_RAILS-1:0] ov_detect,
    input wire logic [fault_supervisor_pkg::NUM_RAILS-1:0] uv_below_300mv,
    input wire logic [fault_supervisor_pkg::NUM_RAILS-1:0] uv_above_250mv,
    input wire logic sense_below_400mv,
    input wire logic open_sense,
    // Averaged current comparators
    input wire logic core_oc_100ua,
    input wire logic core_oc_135ua,
    input wire logic core_oc_145ua,
    input wire logic core_timer_above_2v,
    input wire logic nb_oc_100ua,
    input wire logic nb_oc_135ua,
    // Power save and external phases
    input wire logic power_save_request_in,
    input wire logic [1:0] ext_phase_active,
    output logic power_save_request,
    // Gate control
    output logic core_switch_en,
    output logic nb_switch_en,
    output logic low_side_force,
    output logic ext_phase_low,
    output logic ext_phase_hiz,
    // Timing pin
    output logic core_timer_charge,
    output logic core_timer_discharge,
    // Open-drain power good
    output logic power_good_out_o,
    output logic power_good_out_oe
);
    import fault_supervisor_pkg::*;

    // ****************************************
    // Reset release
    // ****************************************
    logic [1:0] rst_sync_q;
    logic rst_n_sync;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n_sync = rst_sync_q[1];

    // ****************************************
    // Microsecond tick and shutdown wait
    // ****************************************
    sup_state_e state_q, state_d;
    logic [TICK_W-1:0] tick_q;
    logic [WAIT_W-1:0] wait_q;
    logic tick;
    logic wait_done;
    assign tick = (tick_q == TICK_W'(TICK_CYCLES - 1));
    assign wait_done = tick && (wait_q == WAIT_W'(OC_WAIT_TICKS - 1));
    always_ff @(posedge sys_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            tick_q <= '0;
            wait_q <= '0;
        end else begin
            tick_q <= (tick || state_q != ST_OCWAIT) ? '0 : tick_q + 1'b1;
            if (state_q != ST_OCWAIT) begin
                wait_q <= '0;
            end else if (tick) begin
                wait_q <= wait_q + 1'b1;
            end
        end
    end

    // ****************************************
    // Fault decode
    // ****************************************
    logic calm;
    logic ov_any;
    logic ss_trip;
    logic core_run_trip;
    logic nb_run_trip;
    logic oc_trip;
    logic nb_only_trip;
    logic [RETRY_W-1:0] retry_q;
    logic final_trip;
    logic nb_only_q;
    assign ov_any = |ov_detect;
    assign calm = por_ok && !ov_any;
    // Boosted level while ramping covers the output capacitor in-rush
    assign ss_trip = (state_q == ST_SOFT) && (core_oc_135ua || nb_oc_135ua);
    // Dual threshold is armed only in run, never while ramping
    assign core_run_trip = (state_q == ST_RUN) && (core_oc_145ua || (core_oc_100ua && core_timer_above_2v));
    assign nb_run_trip = (state_q == ST_RUN) && nb_oc_100ua;
    assign oc_trip = ss_trip || core_run_trip || nb_run_trip;
    assign nb_only_trip = (state_q == ST_SOFT) ? (nb_oc_135ua && !core_oc_135ua) : (nb_run_trip && !core_run_trip);
    assign final_trip = oc_trip && (retry_q == MAX_RETRIES);

    // ****************************************
    // Supervisor state machine
    // ****************************************
    always_comb begin
        state_d = state_q;
        if (!por_ok) begin
            state_d = ST_OFF;
        end else if (ov_any) begin
            state_d = ST_OVP;
        end else begin
            case (state_q)
                ST_OFF: begin
                    if (enable_in && !open_sense) begin
                        state_d = ST_SOFT;
                    end
                end
                ST_SOFT, ST_RUN: begin
                    if (!enable_in || open_sense) begin
                        state_d = ST_OFF;
                    end else if (final_trip) begin
                        state_d = ST_LATCH;
                    end else if (oc_trip) begin
                        state_d = ST_OCWAIT;
                    end else if (state_q == ST_SOFT && soft_start_done) begin
                        state_d = ST_RUN;
                    end
                end
                ST_OCWAIT: begin
                    if (wait_done) begin
                        state_d = enable_in ? ST_SOFT : ST_OFF;
                    end
                end
                ST_OVP: begin
                    if (sense_below_400mv) begin
                        state_d = ST_LATCH;
                    end
                end
                ST_LATCH: begin
                    state_d = ST_LATCH;
                end
                default: begin
                    state_d = ST_OFF;
                end
            endcase
        end
    end

    // ****************************************
    // Retry counter and sticky flags
    // ****************************************
    logic enter_wait;
    logic ss_complete;
    logic force_normal_q;
    assign enter_wait = calm && (state_d == ST_OCWAIT) && (state_q != ST_OCWAIT);
    assign ss_complete = calm && (state_q == ST_SOFT) && (state_d == ST_RUN);
    always_ff @(posedge sys_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            state_q <= ST_OFF;
            retry_q <= RETRY_ZERO;
            nb_only_q <= 1'b0;
            force_normal_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (!por_ok || ss_complete) begin
                retry_q <= RETRY_ZERO;
            end else if (enter_wait) begin
                retry_q <= retry_q + 1'b1;
            end
            if (enter_wait) begin
                nb_only_q <= nb_only_trip;
            end else if (!por_ok || ss_complete) begin
                nb_only_q <= 1'b0;
            end
            if (calm && oc_trip && !power_save_request_in) begin
                force_normal_q <= 1'b1;
            end else if (!por_ok) begin
                force_normal_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // Undervoltage flags, set wins over release
    // ****************************************
    logic [NUM_RAILS-1:0] uv_q;
    generate
        for (genvar i = 0; i < NUM_RAILS; i++) begin : g_uv
            always_ff @(posedge sys_clk or negedge rst_n_sync) begin
                if (!rst_n_sync) begin
                    uv_q[i] <= 1'b0;
                end else if (uv_below_300mv[i]) begin
                    uv_q[i] <= 1'b1;
                end else if (uv_above_250mv[i]) begin
                    uv_q[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // ****************************************
    // Output decode
    // ****************************************
    logic power_good_flag;
    logic core_sw_d;
    logic nb_sw_d;
    logic low_force_d;
    logic charge_d;
    assign power_good_flag = (state_q == ST_RUN) && calm && enable_in && !open_sense && !oc_trip
        && !(|uv_q) && !(|uv_below_300mv);
    assign core_sw_d = (state_q == ST_SOFT) || (state_q == ST_RUN) || ((state_q == ST_OCWAIT) && nb_only_q);
    assign nb_sw_d = (state_q == ST_SOFT) || (state_q == ST_RUN);
    assign low_force_d = (state_q == ST_OVP) || ((state_q == ST_OFF) && !por_ok);
    assign charge_d = (state_q == ST_RUN) && core_oc_100ua;
    always_ff @(posedge sys_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            power_good_out_oe <= 1'b1;
            core_switch_en <= 1'b0;
            nb_switch_en <= 1'b0;
            low_side_force <= 1'b0;
            ext_phase_low <= 1'b0;
            ext_phase_hiz <= 1'b0;
            core_timer_charge <= 1'b0;
            core_timer_discharge <= 1'b1;
            soft_start_run <= 1'b0;
            power_save_request <= 1'b0;
        end else begin
            power_good_out_oe <= !power_good_flag;
            core_switch_en <= core_sw_d;
            nb_switch_en <= nb_sw_d;
            low_side_force <= low_force_d;
            ext_phase_low <= low_force_d && (|ext_phase_active);
            ext_phase_hiz <= !core_sw_d && !low_force_d && (|ext_phase_active);
            core_timer_charge <= charge_d;
            core_timer_discharge <= !charge_d;
            soft_start_run <= (state_q == ST_SOFT);
            power_save_request <= force_normal_q || power_save_request_in;
        end
    end
    assign power_good_out_o = 1'b0;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n_sync);

    property p_pg_needs_run;
        !power_good_out_oe |-> $past(state_q) == ST_RUN;
    endproperty
    a_pg_needs_run: assert property (p_pg_needs_run) else $error("power good high outside run");

    property p_pg_drops_uv;
        (|uv_below_300mv) |=> power_good_out_oe;
    endproperty
    a_pg_drops_uv: assert property (p_pg_drops_uv) else $error("power good stayed high on undervoltage");

    property p_uv_release;
        $fell(uv_q[RAIL_CORE]) |-> $past(uv_above_250mv[RAIL_CORE]);
    endproperty
    a_uv_release: assert property (p_uv_release) else $error("undervoltage flag released early");

    property p_ov_entry;
        (por_ok && ov_any) |=> (state_q == ST_OVP) ##1 (low_side_force && power_good_out_oe);
    endproperty
    a_ov_entry: assert property (p_ov_entry) else $error("overvoltage did not force low sides");

    property p_ovp_hold;
        (state_q == ST_OVP && por_ok && !sense_below_400mv) |=> state_q == ST_OVP;
    endproperty
    a_ovp_hold: assert property (p_ovp_hold) else $error("low sides released above 400mV");

    property p_latch_hold;
        (state_q == ST_LATCH && por_ok) |=> (state_q == ST_LATCH || state_q == ST_OVP);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("left latch without bias reset");

    property p_pre_por;
        !por_ok [*2] |=> low_side_force;
    endproperty
    a_pre_por: assert property (p_pre_por) else $error("bias loss did not hold low sides");

    property p_wait_hold;
        (state_q == ST_OCWAIT && calm && !wait_done) |=> state_q == ST_OCWAIT;
    endproperty
    a_wait_hold: assert property (p_wait_hold) else $error("shutdown wait ended early");

    property p_final_latch;
        (calm && enable_in && !open_sense && final_trip) |=> state_q == ST_LATCH;
    endproperty
    a_final_latch: assert property (p_final_latch) else $error("final retry did not latch");

    property p_retry_clear;
        ss_complete |=> retry_q == RETRY_ZERO;
    endproperty
    a_retry_clear: assert property (p_retry_clear) else $error("retry counter not cleared");

    property p_fast_trip;
        (state_q == ST_RUN && calm && enable_in && !open_sense && core_oc_145ua)
            |=> (state_q == ST_OCWAIT || state_q == ST_LATCH);
    endproperty
    a_fast_trip: assert property (p_fast_trip) else $error("145uA did not trip");

    property p_timer_discharge;
        (state_q == ST_RUN && !core_oc_100ua) |=> core_timer_discharge && !core_timer_charge;
    endproperty
    a_timer_discharge: assert property (p_timer_discharge) else $error("timing pin not grounded");

    property p_nb_only;
        (state_q == ST_OCWAIT && nb_only_q) |=> core_switch_en && !nb_switch_en;
    endproperty
    a_nb_only: assert property (p_nb_only) else $error("northbridge trip stopped core");

    c_hiccup: cover property (state_q == ST_RUN ##1 state_q == ST_OCWAIT);
    c_retry_start: cover property (state_q == ST_OCWAIT ##1 state_q == ST_SOFT);
    c_ov_latch: cover property (state_q == ST_OVP ##1 state_q == ST_LATCH);
    c_pg_high: cover property ($fell(power_good_out_oe));
endmodule // dual_rail_fault_supervisor
`default_nettype wire

// file: dual_rail_fault_supervisor_bench.sv
`timescale 1ns/100ps
`default_nettype none
module dual_rail_fault_supervisor_bench;
    import fault_supervisor_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    logic sys_clk, rst_n, por_ok, enable_in, sense_below_400mv, open_sense;
    logic [1:0] ov_detect, uv_below_300mv, uv_above_250mv, ext_phase_active;
    logic core_oc_100ua, core_oc_135ua, core_oc_145ua, core_timer_above_2v;
    logic nb_oc_100ua, nb_oc_135ua, power_save_request_in;
    logic soft_start_done, soft_start_run, power_save_request, core_switch_en, nb_switch_en;
    logic low_side_force, ext_phase_low, ext_phase_hiz, core_timer_charge, core_timer_discharge;
    logic power_good_out_o, power_good_out_oe, power_good_out;
    int n_mismatch = 0;
    int cmp_count = 0;
    int n;
    // Short wait keeps the hiccup period at a hundred cycles
    localparam int unsigned WAIT_CYC = 5 * TICK_CYCLES;
    dual_rail_fault_supervisor #(.OC_WAIT_TICKS(5)) dut (.sys_clk, .rst_n, .por_ok, .enable_in,
        .soft_start_done, .soft_start_run, .ov_detect, .uv_below_300mv, .uv_above_250mv,
        .sense_below_400mv, .open_sense, .core_oc_100ua, .core_oc_135ua, .core_oc_145ua,
        .core_timer_above_2v, .nb_oc_100ua, .nb_oc_135ua, .power_save_request_in,
        .ext_phase_active, .power_save_request, .core_switch_en, .nb_switch_en, .low_side_force,
        .ext_phase_low, .ext_phase_hiz, .core_timer_charge, .core_timer_discharge,
        .power_good_out_o, .power_good_out_oe);
    power_stage_model model (.sys_clk, .soft_start_run, .pg_o(power_good_out_o),
        .pg_oe(power_good_out_oe), .soft_start_done, .power_good_out);
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // ****************************************
    // Common tasks
    // ****************************************
    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge sys_clk);
        #1;
    endtask
    task automatic check(input logic [15:0] e, input logic [15:0] a);
        cmp_count++;
        if (a !== e) begin
            n_mismatch++;
            $display("mismatch at %0t: expected %h got %h", $time, e, a);
        end
    endtask
    task automatic wait_run(input int lim);
        n = 0;
        while (soft_start_run !== 1'b1) begin
            if (n == lim) begin
                n_mismatch++;
                stop_test();
            end
            tick(1);
            n++;
        end
    endtask
    task automatic wait_pg();
        for (int i = 0; power_good_out !== 1'b1; i++) begin
            if (i == 50) begin
                n_mismatch++;
                stop_test();
            end
            tick(1);
        end
    endtask
    task automatic start_up();
        por_ok = 1'b1;
        enable_in = 1'b1;
        wait_run(200);
        check(1'b0, power_good_out);
        wait_pg();
        check(1'b1, core_switch_en);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_uv();
        uv_below_300mv = 2'h3;
        uv_above_250mv = 2'h0;
        tick(3);
        check(1'b0, power_good_out);
        check(1'b1, nb_switch_en);
        uv_below_300mv = 2'h0;
        tick(3);
        check(1'b0, power_good_out);
        uv_above_250mv = 2'h3;
        tick(3);
        check(1'b1, power_good_out);
    endtask
    task automatic t_nb_oc();
        nb_oc_100ua = 1'b1;
        tick(3);
        check(1'b0, power_good_out);
        check(1'b0, nb_switch_en);
        check(1'b1, core_switch_en);
        check(1'b0, ext_phase_hiz);
        nb_oc_100ua = 1'b0;
        wait_run(200);
        check(1'b1, n + 3 >= WAIT_CYC && n + 3 <= WAIT_CYC + 6);
        wait_pg();
    endtask
    task automatic t_latch();
        logic prev;
        logic [15:0] rises;
        rises = 0;
        prev = 1'b0;
        nb_oc_100ua = 1'b1;
        nb_oc_135ua = 1'b1;
        repeat (1300) begin
            tick(1);
            if (soft_start_run === 1'b1 && !prev) rises++;
            prev = soft_start_run;
        end
        check(16'h7, rises);
        check(1'b0, core_switch_en);
        nb_oc_100ua = 1'b0;
        nb_oc_135ua = 1'b0;
        enable_in = 1'b0;
        tick(2);
        enable_in = 1'b1;
        tick(200);
        check(1'b0, soft_start_run);
        check(1'b0, power_good_out);
        por_ok = 1'b0;
        tick(3);
        start_up();
    endtask
    task automatic t_ov();
        ov_detect = 2'h1;
        tick(3);
        check(1'b1, low_side_force);
        check(1'b1, ext_phase_low);
        check(1'b0, core_switch_en);
        check(1'b0, power_good_out);
        ov_detect = 2'h0;
        tick(5);
        check(1'b1, low_side_force);
        sense_below_400mv = 1'b1;
        tick(3);
        check(1'b0, low_side_force);
        ov_detect = 2'h2;
        tick(3);
        check(1'b1, low_side_force);
        ov_detect = 2'h0;
        tick(150);
        check(1'b0, soft_start_run);
        por_ok = 1'b0;
        tick(3);
        check(1'b1, low_side_force);
        sense_below_400mv = 1'b0;
        start_up();
    endtask
    task automatic t_core();
        core_oc_100ua = 1'b1;
        tick(3);
        check(1'b1, core_timer_charge);
        check(1'b1, power_good_out);
        core_oc_100ua = 1'b0;
        tick(3);
        check(1'b1, core_timer_discharge);
        check(1'b0, core_timer_charge);
        core_oc_100ua = 1'b1;
        core_timer_above_2v = 1'b1;
        tick(3);
        check(1'b0, power_good_out);
        check(1'b1, ext_phase_hiz);
        check(1'b0, nb_switch_en);
        core_oc_100ua = 1'b0;
        core_timer_above_2v = 1'b0;
        start_up();
        power_save_request_in = 1'b0;
        core_oc_145ua = 1'b1;
        tick(3);
        check(1'b0, power_good_out);
        core_oc_145ua = 1'b0;
        wait_run(200);
        check(1'b1, power_save_request);
        wait_pg();
    endtask
    task automatic t_open();
        open_sense = 1'b1;
        tick(3);
        check(1'b0, power_good_out);
        check(1'b0, core_switch_en);
        tick(150);
        check(1'b0, soft_start_run);
        open_sense = 1'b0;
        wait_run(20);
        wait_pg();
    endtask
    // A fault below the boosted level lets the ramp finish, then trips in run
    task automatic t_boost();
        nb_oc_100ua = 1'b1;
        wait_run(200);
        tick(3);
        check(1'b1, soft_start_run);
        tick(10);
        check(1'b0, nb_switch_en);
        check(1'b0, power_good_out);
        nb_oc_100ua = 1'b0;
        wait_run(200);
        wait_pg();
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {rst_n, por_ok, enable_in, sense_below_400mv, open_sense} = 5'h0;
        {ov_detect, uv_below_300mv} = 4'h0;
        uv_above_250mv = 2'h3;
        ext_phase_active = 2'h3;
        {core_oc_100ua, core_oc_135ua, core_oc_145ua, core_timer_above_2v} = 4'h0;
        {nb_oc_100ua, nb_oc_135ua} = 2'h0;
        power_save_request_in = 1'b1;
        tick(20);
        check(1'b1, power_good_out_oe);
        check(1'b1, core_timer_discharge);
        rst_n = 1'b1;
        tick(3);
        start_up();
        t_uv();
        t_nb_oc();
        t_latch();
        t_ov();
        t_core();
        t_open();
        t_boost();
        stop_test();
    end
endmodule // dual_rail_fault_supervisor_bench
`default_nettype wire

// file: fault_supervisor_pkg.sv
`default_nettype none
package fault_supervisor_pkg;
    // ****************************************
    // Timing
    // ****************************************
    localparam int unsigned SYS_CLK_HZ = 20_000_000;
    localparam int unsigned TICK_HZ = 1_000_000;
    localparam int unsigned TICK_CYCLES = SYS_CLK_HZ / TICK_HZ;
    localparam int unsigned TICK_W = 5;
    localparam int unsigned OC_WAIT_TIME_MS = 12;
    localparam int unsigned OC_WAIT_TICKS_DEF = OC_WAIT_TIME_MS * (TICK_HZ / 1000);
    localparam int unsigned WAIT_W = 14;
    // ****************************************
    // Retry and rails
    // ****************************************
    localparam int unsigned RETRY_W = 3;
    localparam logic [RETRY_W-1:0] MAX_RETRIES = 3'h7;
    localparam logic [RETRY_W-1:0] RETRY_ZERO = 3'h0;
    localparam int unsigned NUM_RAILS = 2;
    localparam int unsigned RAIL_CORE = 0;
    localparam int unsigned RAIL_NB = 1;
    // ****************************************
    // Supervisor states
    // ****************************************
    typedef enum logic [5:0] {
        ST_OFF = 6'h01,
        ST_SOFT = 6'h02,
        ST_RUN = 6'h04,
        ST_OCWAIT = 6'h08,
        ST_OVP = 6'h10,
        ST_LATCH = 6'h20
    } sup_state_e;
endpackage
`default_nettype wire

// file: power_stage_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Ramp and power good monitor
// ****************************************
module power_stage_model #(
    parameter int RAMP_CYCLES = 8
) (
    // Clock
    input wire logic sys_clk,
    // Supervisor side
    input wire logic soft_start_run,
    input wire logic pg_o,
    input wire logic pg_oe,
    output wire logic soft_start_done,
    // Monitor side
    output wire logic power_good_out
);
    int cnt;
    // Pull-up: the pin only reads low while it is pulled low
    assign power_good_out = (pg_oe && !pg_o) ? 1'b0 : 1'b1;
    // Ramp finishes a fixed time after soft-start begins, so a trip can land first
    always @(posedge sys_clk) begin
        if (!soft_start_run) cnt <= 0;
        else if (cnt < RAMP_CYCLES) cnt <= cnt + 1;
    end
    assign soft_start_done = (cnt == RAMP_CYCLES);
endmodule // power_stage_model
`default_nettype wire
